// ==== pkg/cdsc_consts.vh ====
/*
  Constants for the clock delay and sync configuration slice:
  register indices, field positions, reset values and code limits.
  Assumes inclusion by the single design file of the slice.
*/
`ifndef CDSC_CONSTS_VH
`define CDSC_CONSTS_VH

// Register indices on the serial port
`define CDSC_ADDR_COARSE      4'hc
`define CDSC_ADDR_FINE        4'hd
`define CDSC_ADDR_SYNC        4'he
`define CDSC_ADDR_RSVD_F      4'hf

// Reset values
`define CDSC_RST_COARSE       16'h0004
`define CDSC_RST_FINE         16'h0000
`define CDSC_RST_SYNC         16'h0003

// Writable bit masks, reserved bits read as zero
`define CDSC_MASK_COARSE      16'hfffc
`define CDSC_MASK_FINE        16'hfdff
`define CDSC_MASK_SYNC        16'hffdf

// Coarse delay register fields
`define CDSC_COARSE_HI        15
`define CDSC_COARSE_LO        4
`define CDSC_APT_SEL_BIT      3
`define CDSC_DCC_BIT          2

// Fine delay register fields
`define CDSC_FINE_HI          15
`define CDSC_FINE_LO          10
`define CDSC_DLY_FLT_SEL_BIT  8
`define CDSC_TANK_HI          7
`define CDSC_TANK_LO          0

// Sync register fields
`define CDSC_REFDLY_HI        15
`define CDSC_REFDLY_LO        6
`define CDSC_PHASE_HI         4
`define CDSC_PHASE_LO         3
`define CDSC_FOLLOWER_BIT     2
`define CDSC_REFOUT_DIS_BIT   1
`define CDSC_OUTPUT_CLOCK_RESET_INPUT_EN_BIT  0

// Saturation limits
`define CDSC_COARSE_MAX       12'h97f
`define CDSC_REFDLY_MAX       10'h27f

// Serial frame layout
`define CDSC_HDR_BITS         5'h08
`define CDSC_FRAME_BITS       5'h18
`define CDSC_HDR_READ_BIT     7
`define CDSC_HDR_IDX_HI       3
`define CDSC_HDR_IDX_LO       0

`endif

// ==== verilog/cdsc_config.v ====
/*
  Clock delay and multi-chip sync configuration slice. Holds the three
  registers at 0xc..0xe behind a serial control port and drives the
  effective delay, filter, phase and reference clock controls.
  Assumes serial pins and ref clock input are asynchronous to ref_clk_in;
  the serial clock is far slower than ref_clk_in (at least 8x).
  Frame: 8-bit header (bit 7 = read, bits 3:0 = index), 16 data bits,
  MSB first, sampled on rising serial clock, read data shifted on falling.
*/
`timescale 1ns/1ps
`include "cdsc_consts.vh"

module cdsc_config (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_in,
  // Serial control port
  input  wire        scs_n_in,
  input  wire        sclk_in,
  input  wire        sdi_in,
  output reg         sdo_out,
  output reg         sdo_oe_out,
  // Sync pins
  input  wire        ref_clock_in,
  input  wire        output_clock_reset_input_in,
  output reg         ref_clock_out_a_out,
  output reg         ref_clock_out_b_out,
  output reg         data_clock_reset_out,
  // Aperture delay and clock conditioning
  output reg  [11:0] coarse_aperture_delay_out,
  output reg  [5:0]  fine_aperture_delay_out,
  output reg         duty_cycle_correct_out,
  output reg         tank_filter_enable_out,
  output reg  [7:0]  tank_center_freq_out,
  // Reference clock alignment
  output reg  [9:0]  ref_clock_delay_out,
  output reg  [1:0]  ref_phase_select_out,
  output reg         follower_role_out
);

  // Synchroniser stages
  reg  [1:0]  scs_sync;
  reg  [1:0]  sclk_sync;
  reg  [1:0]  sdi_sync;
  reg  [1:0]  refin_sync;
  reg  [1:0]  dcrst_sync;
  reg         sclk_prev;
  reg         refin_prev;

  // Registers
  reg  [15:0] coarse_delay_control;
  reg  [15:0] fine_delay_filter_control;
  reg  [15:0] multi_chip_sync_control;

  // Serial engine
  reg  [4:0]  bit_cnt;
  reg  [15:0] shift_in;
  reg  [15:0] shift_out;
  reg         read_frame;
  reg  [3:0]  frame_addr;

  // Clock divider
  reg  [1:0]  div_cnt;

  wire        sel_active;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        ref_rise;
  wire        frame_on;
  wire [4:0]  next_bit_cnt;
  wire [15:0] next_shift_in;
  wire [11:0] coarse_code;
  wire [9:0]  refdly_code;
  reg  [15:0] read_data;

  assign frame_on     = ~scs_sync[1];
  assign sclk_rise    = sclk_sync[1] & ~sclk_prev;
  assign sclk_fall    = ~sclk_sync[1] & sclk_prev;
  assign ref_rise     = refin_sync[1] & ~refin_prev;
  assign next_bit_cnt = bit_cnt + 5'h01;
  assign next_shift_in = {shift_in[14:0], sdi_sync[1]};

  assign sel_active = coarse_delay_control[`CDSC_APT_SEL_BIT] |
                      fine_delay_filter_control[`CDSC_DLY_FLT_SEL_BIT];
  assign coarse_code = coarse_delay_control[`CDSC_COARSE_HI:`CDSC_COARSE_LO];
  assign refdly_code = multi_chip_sync_control[`CDSC_REFDLY_HI:`CDSC_REFDLY_LO];

  // Two-flop synchronisers for all pin inputs
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scs_sync   <= 2'h3;
      sclk_sync  <= 2'h0;
      sdi_sync   <= 2'h0;
      refin_sync <= 2'h0;
      dcrst_sync <= 2'h0;
      sclk_prev  <= 1'b0;
      refin_prev <= 1'b0;
    end else begin
      scs_sync   <= {scs_sync[0], scs_n_in};
      sclk_sync  <= {sclk_sync[0], sclk_in};
      sdi_sync   <= {sdi_sync[0], sdi_in};
      refin_sync <= {refin_sync[0], ref_clock_in};
      dcrst_sync <= {dcrst_sync[0], output_clock_reset_input_in};
      sclk_prev  <= sclk_sync[1];
      refin_prev <= refin_sync[1];
    end
  end

  // Readback mux, reserved bits and register F read as zero
  always @* begin
    case (frame_addr)
      `CDSC_ADDR_COARSE: read_data = coarse_delay_control;
      `CDSC_ADDR_FINE:   read_data = fine_delay_filter_control;
      `CDSC_ADDR_SYNC:   read_data = multi_chip_sync_control;
      default:           read_data = 16'h0000;
    endcase
  end

  // Serial frame engine and register writes
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt                   <= 5'h00;
      shift_in                  <= 16'h0000;
      shift_out                 <= 16'h0000;
      read_frame                <= 1'b0;
      frame_addr                <= 4'h0;
      sdo_out                   <= 1'b0;
      sdo_oe_out                <= 1'b0;
      coarse_delay_control      <= `CDSC_RST_COARSE;
      fine_delay_filter_control <= `CDSC_RST_FINE;
      multi_chip_sync_control   <= `CDSC_RST_SYNC;
    end else if (!frame_on) begin
      bit_cnt    <= 5'h00;
      read_frame <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else begin
      if (sclk_rise && bit_cnt != `CDSC_FRAME_BITS) begin
        bit_cnt  <= next_bit_cnt;
        shift_in <= next_shift_in;
        if (next_bit_cnt == `CDSC_HDR_BITS) begin
          read_frame <= next_shift_in[`CDSC_HDR_READ_BIT];
          frame_addr <= next_shift_in[`CDSC_HDR_IDX_HI:`CDSC_HDR_IDX_LO];
        end
        if (next_bit_cnt == `CDSC_FRAME_BITS && !read_frame) begin
          // Writes to register F and unmapped indices are dropped
          case (frame_addr)
            `CDSC_ADDR_COARSE:
              coarse_delay_control <= next_shift_in & `CDSC_MASK_COARSE;
            `CDSC_ADDR_FINE:
              fine_delay_filter_control <= next_shift_in & `CDSC_MASK_FINE;
            `CDSC_ADDR_SYNC:
              multi_chip_sync_control <= next_shift_in & `CDSC_MASK_SYNC;
            default: ;
          endcase
        end
      end
      if (sclk_fall && read_frame) begin
        if (bit_cnt == `CDSC_HDR_BITS) begin
          sdo_out    <= read_data[15];
          shift_out  <= {read_data[14:0], 1'b0};
          sdo_oe_out <= 1'b1;
        end else if (bit_cnt == `CDSC_FRAME_BITS) begin
          sdo_oe_out <= 1'b0;
        end else begin
          sdo_out   <= shift_out[15];
          shift_out <= {shift_out[14:0], 1'b0};
        end
      end
    end
  end

  // Effective clock path controls
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      coarse_aperture_delay_out <= 12'h000;
      fine_aperture_delay_out   <= 6'h00;
      duty_cycle_correct_out    <= 1'b1;
      tank_filter_enable_out    <= 1'b0;
      tank_center_freq_out      <= 8'h00;
      ref_clock_delay_out       <= 10'h000;
      ref_phase_select_out      <= 2'h0;
      follower_role_out         <= 1'b0;
      data_clock_reset_out      <= 1'b0;
    end else begin
      if (!sel_active)
        coarse_aperture_delay_out <= 12'h000;
      else if (coarse_code > `CDSC_COARSE_MAX)
        coarse_aperture_delay_out <= `CDSC_COARSE_MAX;
      else
        coarse_aperture_delay_out <= coarse_code;
      fine_aperture_delay_out <= sel_active ?
        fine_delay_filter_control[`CDSC_FINE_HI:`CDSC_FINE_LO] : 6'h00;
      duty_cycle_correct_out <= coarse_delay_control[`CDSC_DCC_BIT];
      tank_filter_enable_out <= fine_delay_filter_control[`CDSC_DLY_FLT_SEL_BIT];
      // Thermometer code passed through; 0 is highest centre frequency
      tank_center_freq_out <= fine_delay_filter_control[`CDSC_TANK_HI:`CDSC_TANK_LO];
      ref_clock_delay_out <= (refdly_code > `CDSC_REFDLY_MAX) ?
                             `CDSC_REFDLY_MAX : refdly_code;
      // 00 none, 01 90, 10 180, 11 270 degrees
      ref_phase_select_out <=
        multi_chip_sync_control[`CDSC_PHASE_HI:`CDSC_PHASE_LO];
      follower_role_out <= multi_chip_sync_control[`CDSC_FOLLOWER_BIT];
      data_clock_reset_out <= dcrst_sync[1] &
        multi_chip_sync_control[`CDSC_OUTPUT_CLOCK_RESET_INPUT_EN_BIT];
    end
  end

  // Divide by four; follower realigns on reference clock rising edge
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt             <= 2'h0;
      ref_clock_out_a_out <= 1'b0;
      ref_clock_out_b_out <= 1'b0;
    end else begin
      if (multi_chip_sync_control[`CDSC_FOLLOWER_BIT] && ref_rise)
        div_cnt <= 2'h0;
      else
        div_cnt <= div_cnt + 2'h1;
      if (multi_chip_sync_control[`CDSC_REFOUT_DIS_BIT]) begin
        ref_clock_out_a_out <= 1'b0;
        ref_clock_out_b_out <= 1'b0;
      end else begin
        ref_clock_out_a_out <= ~div_cnt[1];
        ref_clock_out_b_out <= ~div_cnt[1];
      end
    end
  end

endmodule // cdsc_config

// ==== sim/cdsc_assertions.sv ====
/* Port checker for the clock delay and sync configuration slice.
   Assumes a bind to cdsc_config, whose ports carry the same names. */
`timescale 1ns/1ps
module cdsc_assertions (
  // Clock, reset and pins
  input wire logic        ref_clk_in, rst_in, scs_n_in, output_clock_reset_input_in,
  // Observed outputs
  input wire logic        sdo_oe_out, ref_clock_out_a_out, ref_clock_out_b_out,
  input wire logic        data_clock_reset_out,
  input wire logic        duty_cycle_correct_out, follower_role_out,
  input wire logic [11:0] coarse_aperture_delay_out,
  input wire logic [5:0]  fine_aperture_delay_out,
  input wire logic [9:0]  ref_clock_delay_out,
  input wire logic [1:0]  ref_phase_select_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_coarse_sat_max: assert property (coarse_aperture_delay_out <= 12'h97f)
    else $error("coarse delay above its saturation code");
  a_refdly_sat_max: assert property (ref_clock_delay_out <= 10'h27f)
    else $error("reference delay above its saturation code");
  a_reset_gated_delay: assert property ($fell(rst_in) |->
    coarse_aperture_delay_out == 12'h000 && fine_aperture_delay_out == 6'h00)
    else $error("delays not gated off after reset");
  a_reset_duty_on: assert property ($fell(rst_in) |->
    duty_cycle_correct_out && !ref_clock_out_a_out && !follower_role_out)
    else $error("wrong clock controls after reset");
  a_refout_pair_equal: assert property (ref_clock_out_a_out == ref_clock_out_b_out)
    else $error("reference outputs differ");
  a_refout_quarter_rate: assert property ($rose(ref_clock_out_a_out) ##1
    (ref_clock_out_a_out && !follower_role_out) |=> !ref_clock_out_a_out ##1
    !ref_clock_out_a_out ##1 ref_clock_out_a_out)
    else $error("reference output not a divide by four wave");
  a_output_clock_reset_input_quiet: assert property (!output_clock_reset_input_in [*5] |->
    !data_clock_reset_out)
    else $error("data clock reset out high with pin low");
  a_sync_cfg_stable: assert property (scs_n_in [*8] |->
    $stable(follower_role_out) && $stable(ref_phase_select_out))
    else $error("sync controls changed without a frame");
  cover property (coarse_aperture_delay_out == 12'h97f);
  cover property ($rose(ref_clock_out_a_out));
  cover property (sdo_oe_out);
  cover property (follower_role_out);
endmodule // cdsc_assertions

bind cdsc_config cdsc_assertions chk_u (.*);

// ==== sim/cdsc_host_model.sv ====
/* Host controller model: frames on the serial control port.
   Assumes ref_clk_in at 100 MHz; each serial clock phase lasts 5 cycles. */
`timescale 1ns/1ps
module cdsc_host_model (
  // Clock and read data from the device
  input  wire logic        ref_clk_in,
  input  wire logic        sdo_out,
  input  wire logic        sdo_oe_out,
  // Serial pins and read results
  output logic             scs_n_in,
  output logic             sclk_in,
  output logic             sdi_in,
  output logic             rd_valid_out,
  output logic [15:0]      rd_data_out
);
  initial begin
    scs_n_in = 1'b1;
    sclk_in = 1'b0;
    sdi_in = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 16'h0000;
  end
  task automatic xfer(input logic rd, input logic [3:0] idx, input logic [15:0] wdata);
    logic [23:0] frame;
    frame = {rd, 3'h0, idx, wdata};
    if (rd || idx != 4'hf) begin
      scs_n_in = 1'b0;
      for (int i = 23; i >= 0; i--) begin
        sdi_in = frame[i];
        repeat (5) @(negedge ref_clk_in);
        // Unshifted or undriven bits become unknown
        if (i < 16)
          rd_data_out[i] = sdo_oe_out ? sdo_out : 1'bx;
        sclk_in = 1'b1;
        repeat (5) @(negedge ref_clk_in);
        sclk_in = 1'b0;
      end
      repeat (5) @(negedge ref_clk_in);
      scs_n_in = 1'b1;
      rd_valid_out = rd;
      @(negedge ref_clk_in);
      rd_valid_out = 1'b0;
      repeat (4) @(negedge ref_clk_in);
    end
  endtask
endmodule // cdsc_host_model

// ==== sim/clock_delay_sync_config_test.sv ====
/* Self-checking bench for cdsc_config with the host model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module clock_delay_sync_config_test;
  logic        ref_clk_in = 1'b0, rst_in = 1'b1, ref_clock_in = 1'b0;
  logic        output_clock_reset_input_in = 1'b0;
  logic        scs_n_in, sclk_in, sdi_in, sdo_out, sdo_oe_out, rd_valid_out;
  logic        ref_clock_out_a_out, ref_clock_out_b_out, data_clock_reset_out;
  logic        duty_cycle_correct_out, tank_filter_enable_out, follower_role_out;
  logic [15:0] rd_data_out, wv, rexp, exp_q[$];
  logic [15:0] rstv [3] = '{16'h0004, 16'h0000, 16'h0003};
  logic [11:0] coarse_aperture_delay_out, code, sat, ce;
  logic [11:0] cdv [3] = '{12'd2431, 12'd2432, 12'hfff};
  logic [9:0]  ref_clock_delay_out, rdly, rdv [4] = '{10'd638, 10'd639, 10'd640, 10'h3ff};
  logic [5:0]  fine_aperture_delay_out;
  logic [7:0]  tank_center_freq_out;
  logic [1:0]  ref_phase_select_out;
  int          fail_count = 0, check_count = 0, cycles = 0, seed = 32'h66964d25, highs;

  cdsc_config dut_u (.*);
  cdsc_host_model host_u (.*);

  always #5 ref_clk_in = ~ref_clk_in;
  always #80 ref_clock_in = ~ref_clock_in;

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [15:0] v);
    host_u.xfer(1'b0, idx, v);
    exp_q.push_back(v);
    host_u.xfer(1'b1, idx, 16'h0000);
  endtask

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end else if (rd_valid_out === 1'b1) begin
      rexp = exp_q.pop_front();
      `CHK("readback", rexp, rd_data_out)
    end
  end

  initial begin
    repeat (5) @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    `CHK("duty", 1'b1, duty_cycle_correct_out)
    `CHK("refout", 1'b0, ref_clock_out_a_out)
    foreach (rstv[i]) begin
      exp_q.push_back(rstv[i]);
      host_u.xfer(1'b1, 4'hc + 4'(i), 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      code = (i < 3) ? cdv[i] : 12'($random(seed));
      wv = {code, 1'(i != 3 && i != 5), i[0], 2'b00};
      sat = (code > 12'd2431) ? 12'h97f : code;
      ce = wv[3] ? sat : 12'h000;
      wr(4'hc, wv);
      `CHK("coarse", ce, coarse_aperture_delay_out)
      `CHK("duty", wv[2], duty_cycle_correct_out)
    end
    for (int i = 0; i < 9; i++) begin
      wv = {6'($random(seed)), 1'b0, i[0], 8'hff >> (8 - i)};
      wr(4'hd, wv);
      `CHK("fine", wv[8] ? wv[15:10] : 6'h00, fine_aperture_delay_out)
      `CHK("coarse_sa", wv[8] ? sat : 12'h000, coarse_aperture_delay_out)
      `CHK("tank_en", wv[8], tank_filter_enable_out)
      `CHK("tank", wv[7:0], tank_center_freq_out)
    end
    for (int i = 0; i < 4; i++) begin
      rdly = rdv[i];
      output_clock_reset_input_in = 1'($random(seed));
      wv = {rdly, 1'b0, 2'(i), i[0], 1'b1, 1'($random(seed))};
      wr(4'he, wv);
      `CHK("refdly", rdly > 10'd639 ? 10'd639 : rdly, ref_clock_delay_out)
      `CHK("phase", 2'(i), ref_phase_select_out)
      `CHK("follower", i[0], follower_role_out)
      `CHK("refout_off", 1'b0, ref_clock_out_a_out | ref_clock_out_b_out)
      `CHK("output_clock_reset_input", wv[0] & output_clock_reset_input_in, data_clock_reset_out)
    end
    // Follower already set: outputs on, wave aligned to reference rise
    wr(4'he, 16'h0004);
    @(posedge ref_clock_in);
    #1;
    repeat (4) @(negedge ref_clk_in);
    `CHK("follow_hi", 1'b1, ref_clock_out_a_out)
    repeat (2) @(negedge ref_clk_in);
    `CHK("follow_lo", 1'b0, ref_clock_out_a_out)
    wr(4'he, 16'h0000);
    highs = 0;
    repeat (16) begin
      @(negedge ref_clk_in);
      highs += (ref_clock_out_a_out === 1'b1 && ref_clock_out_b_out === 1'b1);
    end
    `CHK("refout_high", 8, highs)
    summarize();
  end
endmodule // clock_delay_sync_config_test
